// [rtl/hast_pkg.sv]
package hast_pkg;

  // Clock and tick timing
  localparam int unsigned HAST_CLK_HZ = 125_000_000;
  localparam int unsigned HAST_TICK_MS = 1;
  localparam int unsigned HAST_TICK_CYC = HAST_CLK_HZ / 1000 * HAST_TICK_MS;
  localparam int unsigned HAST_TICK_W = 17;
  localparam int unsigned HAST_HOLD_MIN_MS = 100;
  localparam int unsigned HAST_MS_CNT_W = 7;
  localparam logic [HAST_MS_CNT_W-1:0] HAST_HOLD_MIN_TICKS = HAST_MS_CNT_W'(HAST_HOLD_MIN_MS / HAST_TICK_MS);

  // Current measurements in 0.1 A units: 110.0 A
  localparam int unsigned HAST_CUR_W = 16;
  localparam logic [HAST_CUR_W-1:0] HAST_OVERCUR_LIMIT = 16'h044c;

  // Register indices, byte address is four times the index
  localparam int unsigned HAST_IDX_W = 8;
  localparam logic [HAST_IDX_W-1:0] HAST_IDX_OVERCUR = 8'h06;
  localparam logic [HAST_IDX_W-1:0] HAST_IDX_ALARM = 8'h07;
  localparam logic [HAST_IDX_W-1:0] HAST_IDX_HOLD = 8'h09;
  localparam logic [HAST_IDX_W-1:0] HAST_IDX_CHERR = 8'h0b;
  localparam logic [HAST_IDX_W-1:0] HAST_IDX_IRQ_STAT = 8'h10;
  localparam logic [HAST_IDX_W-1:0] HAST_IDX_IRQ_MASK = 8'h11;

  // Status word layout
  localparam int unsigned HAST_WORD_W = 16;
  localparam int unsigned HAST_BIT_OC_ONE = 0;
  localparam int unsigned HAST_BIT_OC_TWO = 1;
  localparam int unsigned HAST_BIT_HB_ONE = 0;
  localparam int unsigned HAST_BIT_HS_ONE = 1;
  localparam int unsigned HAST_BIT_HB_TWO = 4;
  localparam int unsigned HAST_BIT_HS_TWO = 5;
  localparam int unsigned HAST_BIT_HOLD_ONE = 0;
  localparam int unsigned HAST_BIT_HOLD_TWO = 4;
  localparam int unsigned HAST_NUM_CH = 4;

  // Interrupt event bits, one per status word
  localparam int unsigned HAST_EV_W = 4;
  localparam int unsigned HAST_EV_OVERCUR = 0;
  localparam int unsigned HAST_EV_ALARM = 1;
  localparam int unsigned HAST_EV_HOLD = 2;
  localparam int unsigned HAST_EV_CHERR = 3;

  typedef enum logic {HAST_OUT_OFF, HAST_OUT_ON} hast_on_state_t;

  // Word to bus data, upper bits zero
  function automatic logic [31:0] hast_bus_word(input logic [HAST_WORD_W-1:0] w);
    hast_bus_word = {16'h0000, w};
  endfunction : hast_bus_word

endpackage : hast_pkg

// [rtl/hast_hold_track.sv]
module hast_hold_track
  import hast_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Timing and sources
  input wire logic tick_i,
  input wire logic ctl_on_i,
  input wire logic [HAST_CUR_W-1:0] cur_i,
  // Monitor
  output logic [HAST_CUR_W-1:0] monitor_o,
  output logic hold_o
);

  hast_on_state_t state_ff;
  logic [HAST_MS_CNT_W-1:0] ms_cnt_ff;
  logic long_on;

  assign long_on = (ms_cnt_ff >= HAST_HOLD_MIN_TICKS);

  // ON time measured in whole ticks
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= HAST_OUT_OFF;
      ms_cnt_ff <= '0;
    end else begin
      unique case (state_ff)
        HAST_OUT_OFF: begin
          ms_cnt_ff <= '0;
          if (ctl_on_i) begin
            state_ff <= HAST_OUT_ON;
          end
        end
        HAST_OUT_ON: begin
          if (!ctl_on_i) begin
            state_ff <= HAST_OUT_OFF;
          end else if (tick_i && !long_on) begin
            ms_cnt_ff <= ms_cnt_ff + 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      monitor_o <= '0;
      hold_o <= 1'b0;
    end else if (state_ff == HAST_OUT_ON && long_on) begin
      monitor_o <= cur_i;
      hold_o <= 1'b0;
    end else if (state_ff == HAST_OUT_ON && !ctl_on_i) begin
      hold_o <= 1'b1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_hold_short_pulse: assert property (state_ff == HAST_OUT_ON && !ctl_on_i && !long_on |=>
    hold_o && $stable(monitor_o))
    else $error("short ON pulse did not hold monitor");
  a_update_long_on: assert property (state_ff == HAST_OUT_ON && long_on |=>
    !hold_o && monitor_o == $past(cur_i))
    else $error("long ON time did not update monitor");

endmodule : hast_hold_track

// [rtl/hast_status_top.sv]
// The AHB-Lite slave port was chosen for this implementation.
module hast_status_top
  import hast_pkg::*;
#(
  parameter int unsigned TICK_CYC = HAST_TICK_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Heater current measurements
  input wire logic [HAST_CUR_W-1:0] current_sensor_one_i,
  input wire logic [HAST_CUR_W-1:0] current_sensor_two_i,
  // Heater alarms
  input wire logic heater_burnout_alarm_one_i,
  input wire logic heater_short_alarm_one_i,
  input wire logic heater_burnout_alarm_two_i,
  input wire logic heater_short_alarm_two_i,
  // Control output pins
  input wire logic ctl_out_one_i,
  input wire logic ctl_out_two_i,
  // Channel errors, bit 0 is channel_one
  input wire logic [HAST_NUM_CH-1:0] channel_error_i,
  // Monitors and interrupt
  output logic [HAST_CUR_W-1:0] monitor_one_o,
  output logic [HAST_CUR_W-1:0] monitor_two_o,
  output logic irq_o
);

  localparam logic [HAST_TICK_W-1:0] TICK_LAST = HAST_TICK_W'(TICK_CYC - 1);

  logic [HAST_TICK_W-1:0] tick_cnt_ff;
  logic tick_ff;
  logic [1:0] ctl_meta_ff;
  logic [1:0] ctl_sync_ff;
  logic [1:0] oc_ff;
  logic [3:0] alarm_ff;
  logic [HAST_NUM_CH-1:0] cherr_ff;
  logic [1:0] hold_w;
  logic [HAST_CUR_W-1:0] mon_w [2];
  logic [HAST_CUR_W-1:0] cur_w [2];
  logic [HAST_WORD_W-1:0] oc_word;
  logic [HAST_WORD_W-1:0] alarm_word;
  logic [HAST_WORD_W-1:0] hold_word;
  logic [HAST_WORD_W-1:0] cherr_word;
  logic [HAST_WORD_W-1:0] prev_word_ff [HAST_EV_W];
  logic [HAST_EV_W-1:0] event_w;
  logic [HAST_EV_W-1:0] irq_stat_ff;
  logic [HAST_EV_W-1:0] irq_mask_ff;
  logic [HAST_EV_W-1:0] stat_clr;
  logic [HAST_EV_W-1:0] nxt_irq_stat;
  logic accept;
  logic addr_ok;
  logic [HAST_IDX_W-1:0] idx;
  logic wr_pend_ff;
  logic [HAST_IDX_W-1:0] wr_idx_ff;

  // Millisecond tick divider
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else if (tick_cnt_ff == TICK_LAST) begin
      tick_cnt_ff <= '0;
      tick_ff <= 1'b1;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 1'b1;
      tick_ff <= 1'b0;
    end
  end

  // Control output pin synchronisers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctl_meta_ff <= 2'h0;
      ctl_sync_ff <= 2'h0;
    end else begin
      ctl_meta_ff <= {ctl_out_two_i, ctl_out_one_i};
      ctl_sync_ff <= ctl_meta_ff;
    end
  end

  assign cur_w[0] = current_sensor_one_i;
  assign cur_w[1] = current_sensor_two_i;

  for (genvar s = 0; s < 2; s++) begin : g_track
    hast_hold_track u_track (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tick_i(tick_ff),
      .ctl_on_i(ctl_sync_ff[s]),
      .cur_i(cur_w[s]),
      .monitor_o(mon_w[s]),
      .hold_o(hold_w[s])
    );
  end

  assign monitor_one_o = mon_w[0];
  assign monitor_two_o = mon_w[1];

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      oc_ff <= 2'h0;
    end else begin
      oc_ff[HAST_BIT_OC_ONE] <= (current_sensor_one_i > HAST_OVERCUR_LIMIT);
      oc_ff[HAST_BIT_OC_TWO] <= (current_sensor_two_i > HAST_OVERCUR_LIMIT);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      alarm_ff <= 4'h0;
    end else begin
      alarm_ff <= {heater_short_alarm_two_i, heater_burnout_alarm_two_i,
                   heater_short_alarm_one_i, heater_burnout_alarm_one_i};
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cherr_ff <= '0;
    end else begin
      cherr_ff <= channel_error_i;
    end
  end

  always_comb begin
    oc_word = '0;
    oc_word[HAST_BIT_OC_ONE] = oc_ff[HAST_BIT_OC_ONE];
    oc_word[HAST_BIT_OC_TWO] = oc_ff[HAST_BIT_OC_TWO];
    alarm_word = '0;
    alarm_word[HAST_BIT_HB_ONE] = alarm_ff[0];
    alarm_word[HAST_BIT_HS_ONE] = alarm_ff[1];
    alarm_word[HAST_BIT_HB_TWO] = alarm_ff[2];
    alarm_word[HAST_BIT_HS_TWO] = alarm_ff[3];
    hold_word = '0;
    hold_word[HAST_BIT_HOLD_ONE] = hold_w[0];
    hold_word[HAST_BIT_HOLD_TWO] = hold_w[1];
    cherr_word = '0;
    cherr_word[HAST_NUM_CH-1:0] = cherr_ff;
  end

  // Events: any status bit rising
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < HAST_EV_W; i++) begin
        prev_word_ff[i] <= '0;
      end
    end else begin
      prev_word_ff[HAST_EV_OVERCUR] <= oc_word;
      prev_word_ff[HAST_EV_ALARM] <= alarm_word;
      prev_word_ff[HAST_EV_HOLD] <= hold_word;
      prev_word_ff[HAST_EV_CHERR] <= cherr_word;
    end
  end

  assign event_w[HAST_EV_OVERCUR] = |(oc_word & ~prev_word_ff[HAST_EV_OVERCUR]);
  assign event_w[HAST_EV_ALARM] = |(alarm_word & ~prev_word_ff[HAST_EV_ALARM]);
  assign event_w[HAST_EV_HOLD] = |(hold_word & ~prev_word_ff[HAST_EV_HOLD]);
  assign event_w[HAST_EV_CHERR] = |(cherr_word & ~prev_word_ff[HAST_EV_CHERR]);

  // Bus address phase decode
  assign accept = hsel_i && htrans_i[1] && hready_i;
  assign addr_ok = (haddr_i[31:HAST_IDX_W+2] == '0) && (haddr_i[1:0] == 2'h0);
  assign idx = haddr_i[HAST_IDX_W+1:2];

  // Read of interrupt status clears it, a new event wins
  assign stat_clr = (accept && !hwrite_i && addr_ok && idx == HAST_IDX_IRQ_STAT) ? '1 : '0;
  assign nxt_irq_stat = (irq_stat_ff & ~stat_clr) | event_w;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_stat_ff <= '0;
      irq_o <= 1'b0;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
      irq_o <= |(nxt_irq_stat & irq_mask_ff);
    end
  end

  // Read data for the next data phase
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hrdata_o <= '0;
    end else if (accept && !hwrite_i && addr_ok) begin
      unique case (idx)
        HAST_IDX_OVERCUR: hrdata_o <= hast_bus_word(oc_word);
        HAST_IDX_ALARM: hrdata_o <= hast_bus_word(alarm_word);
        HAST_IDX_HOLD: hrdata_o <= hast_bus_word(hold_word);
        HAST_IDX_CHERR: hrdata_o <= hast_bus_word(cherr_word);
        HAST_IDX_IRQ_STAT: hrdata_o <= hast_bus_word({12'h000, irq_stat_ff});
        HAST_IDX_IRQ_MASK: hrdata_o <= hast_bus_word({12'h000, irq_mask_ff});
        default: hrdata_o <= '0;
      endcase
    end else begin
      hrdata_o <= '0;
    end
  end

  // Zero wait states, always OKAY
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
  end

  // Write address held for data phase
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_pend_ff <= 1'b0;
      wr_idx_ff <= '0;
    end else begin
      wr_pend_ff <= accept && hwrite_i && addr_ok;
      wr_idx_ff <= idx;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_mask_ff <= '0;
    end else if (wr_pend_ff && wr_idx_ff == HAST_IDX_IRQ_MASK) begin
      irq_mask_ff <= hwdata_i[HAST_EV_W-1:0];
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_overcur_one_bit: assert property (1'b1 |=> oc_word[HAST_BIT_OC_ONE] ==
    ($past(current_sensor_one_i) > HAST_OVERCUR_LIMIT))
    else $error("overcurrent one bit wrong");
  a_overcur_two_bit: assert property (##1 oc_word[HAST_BIT_OC_TWO] ==
    ($past(current_sensor_two_i) > HAST_OVERCUR_LIMIT))
    else $error("overcurrent two bit wrong");
  a_overcur_read_zero: assert property (accept && !hwrite_i && addr_ok && idx == HAST_IDX_OVERCUR |=>
    hrdata_o[31:2] == '0)
    else $error("unused overcurrent bits not zero");
  a_burnout_one_bit: assert property (heater_burnout_alarm_one_i |=> alarm_word[HAST_BIT_HB_ONE])
    else $error("burnout one not reported");
  a_burnout_one_off: assert property (!heater_burnout_alarm_one_i |=> !alarm_word[HAST_BIT_HB_ONE])
    else $error("burnout one reported while off");
  a_short_one_bit: assert property (!heater_short_alarm_one_i |=> !alarm_word[HAST_BIT_HS_ONE])
    else $error("short one reported while off");
  a_burnout_two_bit: assert property (heater_burnout_alarm_two_i |=> alarm_word[HAST_BIT_HB_TWO])
    else $error("burnout two not reported");
  a_short_two_bit: assert property (heater_short_alarm_two_i |=> alarm_word[HAST_BIT_HS_TWO])
    else $error("short two not reported");
  a_short_two_off: assert property (!heater_short_alarm_two_i |=> !alarm_word[HAST_BIT_HS_TWO])
    else $error("short two reported while off");
  a_hold_bits_map: assert property (accept && !hwrite_i && addr_ok && idx == HAST_IDX_HOLD |=>
    hrdata_o[HAST_BIT_HOLD_ONE] == $past(hold_w[0]) && hrdata_o[HAST_BIT_HOLD_TWO] == $past(hold_w[1]))
    else $error("hold bits misplaced");
  a_chan_err_word: assert property (##1 cherr_word[HAST_NUM_CH-1:0] == $past(channel_error_i))
    else $error("channel error word wrong");
  a_cherr_read_zero: assert property (accept && !hwrite_i && addr_ok && idx == HAST_IDX_CHERR |=>
    hrdata_o[31:4] == '0)
    else $error("unused channel error bits not zero");
  a_unused_bits_zero: assert property (accept && !hwrite_i && addr_ok && idx == HAST_IDX_ALARM |=>
    hrdata_o[31:6] == '0 && hrdata_o[3:2] == 2'h0)
    else $error("unused alarm bits not zero");
  a_status_ro_write: assert property (accept && hwrite_i && idx == HAST_IDX_OVERCUR ##1 1'b1 |=>
    oc_word[HAST_BIT_OC_ONE] == ($past(current_sensor_one_i) > HAST_OVERCUR_LIMIT))
    else $error("write disturbed status word");
  a_mask_write_only: assert property (!(wr_pend_ff && wr_idx_ff == HAST_IDX_IRQ_MASK) |=> $stable(irq_mask_ff))
    else $error("mask changed without write");
  a_mask_takes_write: assert property (wr_pend_ff && wr_idx_ff == HAST_IDX_IRQ_MASK |=>
    irq_mask_ff == $past(hwdata_i[HAST_EV_W-1:0]))
    else $error("mask write not taken");
  a_irq_clear_read: assert property (accept && !hwrite_i && addr_ok && idx == HAST_IDX_IRQ_STAT && event_w == '0 |=>
    irq_stat_ff == '0)
    else $error("status read did not clear");
  a_event_sets_stat: assert property ((|event_w) |=> (irq_stat_ff & $past(event_w)) == $past(event_w))
    else $error("event lost against status clear");
  a_irq_level_out: assert property (irq_o == |(irq_stat_ff & $past(irq_mask_ff)))
    else $error("interrupt level wrong");
  a_read_idle_zero: assert property (!(accept && !hwrite_i && addr_ok) |=> hrdata_o == '0)
    else $error("read data not zero when idle");
  a_bus_okay_ready: assert property (hreadyout_o && !hresp_o)
    else $error("bus not ready or not okay");
  a_tick_single_pulse: assert property (tick_ff |=> !tick_ff)
    else $error("tick wider than one cycle");

endmodule : hast_status_top

// [verif/hast_host_model.sv]
module hast_host_model (
  // Clock
  input wire logic clk_i,
  // AHB-Lite master
  output logic hsel_o,
  output logic [31:0] haddr_o,
  output logic [1:0] htrans_o,
  output logic hwrite_o,
  output logic [2:0] hsize_o,
  output logic [31:0] hwdata_o,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_i
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    hsel_o = 1'b0;
    haddr_o = 32'h0;
    htrans_o = 2'b00;
    hwrite_o = 1'b0;
    hsize_o = 3'h2;
    hwdata_o = 32'h0;
  end

  // Single word transfer, byte address is four times the index
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_i);
    hsel_o <= 1'b1;
    htrans_o <= 2'b10;
    haddr_o <= {22'h0, idx, 2'b00};
    hwrite_o <= wr;
    hsize_o <= 3'h2;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    hsel_o <= 1'b0;
    htrans_o <= 2'b00;
    hwdata_o <= wd;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    rd = hrdata_i;
  endtask : xfer
endmodule : hast_host_model

// [verif/heater_alarm_status_words_tb_top.sv]
module heater_alarm_status_words_tb_top;
  import hast_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned TICK = 10;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic hsel, hwrite, hready, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] cur1 = 16'h0, cur2 = 16'h0, mon1, mon2;
  logic hb1 = 1'b0, hs1 = 1'b0, hb2 = 1'b0, hs2 = 1'b0, on1 = 1'b0, on2 = 1'b0;
  logic [3:0] cerr = 4'h0;
  int bad_count = 0;
  int samples_checked = 0;

  initial begin
    forever #4 clk_i = ~clk_i;
  end

  hast_host_model i_host (.clk_i(clk_i), .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite),
    .hsize_o(hsize), .hwdata_o(hwdata), .hready_i(hready), .hrdata_i(hrdata));

  hast_status_top #(.TICK_CYC(TICK)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .current_sensor_one_i(cur1),
    .current_sensor_two_i(cur2), .heater_burnout_alarm_one_i(hb1), .heater_short_alarm_one_i(hs1),
    .heater_burnout_alarm_two_i(hb2), .heater_short_alarm_two_i(hs2), .ctl_out_one_i(on1),
    .ctl_out_two_i(on2), .channel_error_i(cerr), .monitor_one_o(mon1), .monitor_two_o(mon2), .irq_o(irq));

  function automatic logic [31:0] exp_oc(input logic [15:0] a, input logic [15:0] b);
    exp_oc = {30'h0, b > HAST_OVERCUR_LIMIT, a > HAST_OVERCUR_LIMIT};
  endfunction : exp_oc

  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      $display("Error %s expected %h seen %h", n, exp, seen);
      bad_count++;
    end
  endtask : check

  task automatic rdchk(input string n, input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    i_host.xfer(1'b0, idx, $urandom, r);
    check(n, r, exp);
  endtask : rdchk

  task automatic pulse(input int ticks);
    on1 <= 1'b1;
    on2 <= 1'b1;
    repeat (ticks * TICK) @(posedge clk_i);
    on1 <= 1'b0;
    on2 <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask : pulse

  task automatic summarize;
    if (bad_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize

  initial begin
    #160000;
    bad_count++;
    summarize();
  end

  initial begin
    void'($urandom(32'hb1fc));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk("oc_rst", HAST_IDX_OVERCUR, 32'h0);
    rdchk("unmapped", 8'h40, 32'h0);
    repeat (40) begin
      @(posedge clk_i);
      cur1 <= ($urandom % 3 == 0) ? 16'(HAST_OVERCUR_LIMIT + $urandom % 2) : 16'($urandom % 2400);
      cur2 <= ($urandom % 3 == 0) ? 16'(HAST_OVERCUR_LIMIT + $urandom % 2) : 16'($urandom % 2400);
      {hb1, hs1, hb2, hs2} <= 4'($urandom);
      cerr <= 4'($urandom);
      @(posedge clk_i);
      rdchk("overcur", HAST_IDX_OVERCUR, exp_oc(cur1, cur2));
      rdchk("alarm", HAST_IDX_ALARM, {26'h0, hs2, hb2, 2'b00, hs1, hb1});
      rdchk("cherr", HAST_IDX_CHERR, {28'h0, cerr});
    end
    {hb1, hs1, hb2, hs2, cerr, cur1, cur2} <= '0;
    repeat (4) @(posedge clk_i);
    i_host.xfer(1'b1, HAST_IDX_IRQ_MASK, 32'h2, d);
    rdchk("mask_rd", HAST_IDX_IRQ_MASK, 32'h2);
    i_host.xfer(1'b0, HAST_IDX_IRQ_STAT, 32'h0, d);
    hb1 <= 1'b1;
    repeat (4) @(posedge clk_i);
    check("irq_on", {31'h0, irq}, 32'h1);
    rdchk("irq_stat", HAST_IDX_IRQ_STAT, 32'h2);
    repeat (2) @(posedge clk_i);
    check("irq_clr", {31'h0, irq}, 32'h0);
    i_host.xfer(1'b1, HAST_IDX_IRQ_MASK, 32'h0, d);
    hb2 <= 1'b1;
    repeat (4) @(posedge clk_i);
    check("irq_mask", {31'h0, irq}, 32'h0);
    rdchk("irq_stat2", HAST_IDX_IRQ_STAT, 32'h2);
    i_host.xfer(1'b1, HAST_IDX_ALARM, 32'hffff_ffff, d);
    i_host.xfer(1'b1, HAST_IDX_CHERR, 32'hffff_ffff, d);
    i_host.xfer(1'b1, HAST_IDX_OVERCUR, 32'hffff_ffff, d);
    rdchk("alarm_wr", HAST_IDX_ALARM, 32'h11);
    rdchk("cherr_wr", HAST_IDX_CHERR, 32'h0);
    rdchk("oc_wr", HAST_IDX_OVERCUR, exp_oc(cur1, cur2));
    cur1 <= 16'd500;
    cur2 <= 16'd700;
    pulse(120);
    check("mon1_upd", {16'h0, mon1}, 32'd500);
    check("mon2_upd", {16'h0, mon2}, 32'd700);
    rdchk("hold_upd", HAST_IDX_HOLD, 32'h0);
    cur1 <= 16'd900;
    cur2 <= 16'd300;
    pulse(50);
    check("mon1_hold", {16'h0, mon1}, 32'd500);
    check("mon2_hold", {16'h0, mon2}, 32'd700);
    rdchk("hold_set", HAST_IDX_HOLD, 32'h11);
    i_host.xfer(1'b1, HAST_IDX_HOLD, 32'h0, d);
    rdchk("hold_wr", HAST_IDX_HOLD, 32'h11);
    check("resp", {31'h0, hresp}, 32'h0);
    check("ready", {31'h0, hready}, 32'h1);
    summarize();
  end
endmodule : heater_alarm_status_words_tb_top
